// ===== pkg/sfic_pkg.sv
// Constants, types and helper functions of the supply fault input block.
// Assumes a single clock domain and a word-aligned Avalon-MM byte address.
package sfic_pkg;

  localparam int NUM_CH     = 10;
  localparam int NUM_DUAL   = 5;
  localparam int FIRST_DUAL = 5;
  localparam int HV_CH      = 0;
  localparam int NUM_SYNC   = 2 * NUM_CH + NUM_DUAL;

  localparam int CLK_HZ_DEF = 10_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int TIME_W     = 7;
  localparam int TIME_US_MAX = 100;
  localparam int THR_FULL   = 255;

  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_TIMING   = 8'h04;
  localparam logic [7:0] ADDR_STATE    = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_CH_BASE  = 8'h40;

  localparam int CTRL_LOGIC_LSB = 0;
  localparam int CTRL_EDGE_LSB  = 5;
  localparam int CTRL_PD_LSB    = 10;
  localparam int CTRL_W         = 15;
  localparam int TIM_FILT_LSB   = 0;
  localparam int TIM_PULSE_LSB  = 8;
  localparam int EV_FAULT_LSB   = 0;
  localparam int EV_WARN_LSB    = 10;
  localparam int EV_LOGIC_LSB   = 15;
  localparam int EV_W           = 20;
  localparam int CFG_W          = 25;

  typedef enum logic [1:0] {
    FT_UNDER,
    FT_OVER,
    FT_WINDOW
  } sfic_ftype_t;

  // Span 0.573..1.375, 1.25..3.00, 2.5..6.0 and 4.8..14.4 volt
  typedef enum logic [1:0] {
    RG_LOW,
    RG_MID,
    RG_POS,
    RG_HIGH
  } sfic_range_t;

  typedef struct packed {
    sfic_range_t rng;
    sfic_ftype_t ftype;
    logic [4:0]  hyst_code;
    logic [7:0]  ov_thr;
    logic [7:0]  uv_thr;
  } sfic_chan_cfg_t;

  typedef struct packed {
    logic [7:0]  uv_code;
    logic [7:0]  ov_code;
    sfic_range_t rng;
    logic        partner_sel;
  } sfic_afe_ctrl_t;

  localparam sfic_chan_cfg_t CFG_RST = '{
    rng: RG_LOW, ftype: FT_UNDER, hyst_code: 5'h00,
    ov_thr: 8'hff, uv_thr: 8'h00
  };

  function automatic sfic_range_t legal_range(input logic [3:0] ch,
                                              input sfic_range_t r);
    if (ch == 4'(HV_CH))
      return (r == RG_HIGH) ? RG_HIGH : RG_POS;
    else if (ch < 4'(FIRST_DUAL))
      return (r == RG_HIGH) ? RG_POS : r;
    else
      return RG_LOW;
  endfunction

  // Dual channel k watches positive input k+1, the last one the HV input
  function automatic int partner_ch(input int k);
    return (k == NUM_DUAL - 1) ? HV_CH : k + 1;
  endfunction

  function automatic logic fault_of(input sfic_ftype_t t,
                                    input logic uv, input logic ov);
    unique case (t)
      FT_UNDER:  return uv;
      FT_OVER:   return ov;
      FT_WINDOW: return uv | ov;
      default:   return uv | ov;
    endcase
  endfunction

  function automatic logic [TIME_W-1:0] clamp_us(input logic [6:0] v);
    return (v > 7'(TIME_US_MAX)) ? TIME_W'(TIME_US_MAX) : v;
  endfunction

endpackage

// ===== src/sfic_glitch_filter.sv
// One-bit glitch filter counting microsecond ticks.
// Assumes a synchronised input and a one-cycle tick enable.
module sfic_glitch_filter #(
  parameter int TW = 7
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic          tick_us_i,
  input  wire logic [TW-1:0] timeout_i,
  input  wire logic          level_i,
  output logic               level_o
);

  logic [TW-1:0] cnt;

  if (TW < 1) begin : g_bad_tw
    $error("sfic_glitch_filter: time width below one bit");
  end

  // A pulse that ends before the count runs out clears the count
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt     <= '0;
      level_o <= 1'b0;
    end else if (level_i == level_o) begin
      cnt <= '0;
    end else if (timeout_i == '0) begin
      level_o <= level_i;
    end else if (tick_us_i) begin
      if (cnt == timeout_i - TW'(1)) begin
        level_o <= level_i;
        cnt     <= '0;
      end else begin
        cnt <= cnt + TW'(1);
      end
    end
  end

endmodule

// ===== src/sfic_top.sv
// Supply fault input conditioning: ten detector channels, five of them
// dual-function, with an Avalon-MM register slave and one interrupt.
// Assumes analog comparators and pins asynchronous to clk_sys_i.
module sfic_top #(
  parameter int CLK_HZ = sfic_pkg::CLK_HZ_DEF,
  parameter int TW     = sfic_pkg::TIME_W
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  input  wire logic [7:0]                  avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [31:0]                 avs_readdata_o,
  output logic                             avs_waitrequest_o,
  input  wire logic [sfic_pkg::NUM_CH-1:0] uv_cmp_i,
  input  wire logic [sfic_pkg::NUM_CH-1:0] ov_cmp_i,
  input  wire logic [sfic_pkg::NUM_DUAL-1:0] dual_function_input_i,
  output sfic_pkg::sfic_afe_ctrl_t [sfic_pkg::NUM_CH-1:0] afe_ctrl_o,
  output logic [sfic_pkg::NUM_DUAL-1:0]    pulldown_en_o,
  output logic [sfic_pkg::NUM_CH-1:0]      fault_o,
  output logic                             warn_o,
  output logic [sfic_pkg::NUM_DUAL-1:0]    logic_cond_o,
  output logic                             irq_o
);

  localparam int NC     = sfic_pkg::NUM_CH;
  localparam int ND     = sfic_pkg::NUM_DUAL;
  localparam int NS     = sfic_pkg::NUM_SYNC;
  localparam int US_DIV = CLK_HZ / sfic_pkg::HZ_PER_MHZ;
  localparam int DW     = $clog2(US_DIV + 1);

  if (US_DIV < 1 || TW != sfic_pkg::TIME_W) begin : g_bad_cfg
    $error("sfic_top: clock below 1 MHz or unsupported time width");
  end

  // Microsecond timebase
  logic [DW-1:0] div_cnt;
  logic          tick_us;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_cnt <= '0;
      tick_us <= 1'b0;
    end else if (div_cnt == DW'(US_DIV - 1)) begin
      div_cnt <= '0;
      tick_us <= 1'b1;
    end else begin
      div_cnt <= div_cnt + DW'(1);
      tick_us <= 1'b0;
    end
  end

  // Two-stage synchronisers, then one filter per signal
  logic [NS-1:0] sync_a;
  logic [NS-1:0] sync_b;
  logic [NS-1:0] flt;
  logic [NS-1:0] raw_in;

  assign raw_in = {dual_function_input_i, ov_cmp_i, uv_cmp_i};

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic [TW-1:0] filt_time;
  logic [TW-1:0] pulse_width;

  for (genvar s = 0; s < NS; s++) begin : g_flt
    // Same filter for comparators and logic pins
    sfic_glitch_filter #(
      .TW (TW)
    ) u_flt (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .tick_us_i (tick_us),
      .timeout_i (filt_time),
      .level_i   (sync_b[s]),
      .level_o   (flt[s])
    );
  end

  wire [NC-1:0] uv_sync = sync_b[NC-1:0];
  wire [NC-1:0] undervoltage_flag = flt[NC-1:0];
  wire [NC-1:0] overvoltage_flag  = flt[2*NC-1:NC];
  wire [ND-1:0] lg_flt = flt[NS-1:2*NC];

  // Configuration state
  logic [sfic_pkg::CTRL_W-1:0] ctrl;
  sfic_pkg::sfic_chan_cfg_t    cfg [NC];
  logic [sfic_pkg::EV_W-1:0]   irq_stat;
  logic [sfic_pkg::EV_W-1:0]   irq_mask;
  logic [ND-1:0]               warn_stat;

  wire [ND-1:0] logic_mode = ctrl[sfic_pkg::CTRL_LOGIC_LSB +: ND];
  wire [ND-1:0] edge_mode  = ctrl[sfic_pkg::CTRL_EDGE_LSB +: ND];
  wire [ND-1:0] pd_sel     = ctrl[sfic_pkg::CTRL_PD_LSB +: ND];

  // Detector decode and the analog-side controls
  logic [NC-1:0]                      det_flag;
  sfic_pkg::sfic_afe_ctrl_t [NC-1:0]  next_afe;

  for (genvar i = 0; i < NC; i++) begin : g_det
    wire [8:0] uv_up = {1'b0, cfg[i].uv_thr} + 9'(cfg[i].hyst_code);
    wire [7:0] ov_dn = (cfg[i].ov_thr > 8'(cfg[i].hyst_code)) ?
                       cfg[i].ov_thr - 8'(cfg[i].hyst_code) : 8'h00;
    assign det_flag[i] = sfic_pkg::fault_of(cfg[i].ftype,
                           undervoltage_flag[i], overvoltage_flag[i]);
    // Trip code moves by the hysteresis only while tripped
    assign next_afe[i].uv_code = !uv_sync[i] ? cfg[i].uv_thr :
                                 (uv_up[8] ? 8'hff : uv_up[7:0]);
    assign next_afe[i].ov_code = sync_b[NC+i] ? ov_dn : cfg[i].ov_thr;
    if (i >= sfic_pkg::FIRST_DUAL) begin : g_dual
      localparam int K = i - sfic_pkg::FIRST_DUAL;
      localparam int P = sfic_pkg::partner_ch(K);
      // Secondary detector borrows the partner range
      assign next_afe[i].rng = logic_mode[K] ? cfg[P].rng : cfg[i].rng;
      assign next_afe[i].partner_sel = logic_mode[K];
    end else begin : g_fixed
      assign next_afe[i].rng = cfg[i].rng;
      assign next_afe[i].partner_sel = 1'b0;
    end
  end

  // A dual channel in logic mode raises warnings, never faults
  wire [NC-1:0] next_fault = det_flag & ~{logic_mode, 5'h00};
  wire [ND-1:0] next_warn  = det_flag[NC-1:ND] & logic_mode;

  // Logic input conditioning
  logic          lg_prev   [ND];
  logic          pulse_act [ND];
  logic [TW-1:0] pw_cnt    [ND];
  logic [ND-1:0] next_logic;

  for (genvar k = 0; k < ND; k++) begin : g_lg
    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        lg_prev[k]   <= 1'b0;
        pulse_act[k] <= 1'b0;
        pw_cnt[k]    <= '0;
      end else begin
        lg_prev[k] <= lg_flt[k];
        if (lg_flt[k] != lg_prev[k]) begin
          pulse_act[k] <= 1'b1;
          pw_cnt[k]    <= pulse_width;
        end else if (pulse_act[k] && pw_cnt[k] == '0) begin
          pulse_act[k] <= 1'b0;
        end else if (pulse_act[k] && tick_us) begin
          pw_cnt[k] <= pw_cnt[k] - TW'(1);
        end
      end
    end
    // Level mode passes the filtered pin straight on
    assign next_logic[k] = logic_mode[k] &
                           (edge_mode[k] ? pulse_act[k] : lg_flt[k]);
  end

  // Events for the interrupt status
  wire [sfic_pkg::EV_W-1:0] events = {next_logic & ~logic_cond_o,
                                      next_warn & ~warn_stat,
                                      next_fault & ~fault_o};

  // Avalon-MM slave: one wait cycle, then completion
  wire        bus_req = avs_read_i | avs_write_i;
  wire        commit  = bus_req & ~avs_waitrequest_o;
  wire        wr_en   = commit & avs_write_i;
  wire [7:0]  ch_off  = avs_address_i - sfic_pkg::ADDR_CH_BASE;
  wire        ch_hit  = (avs_address_i >= sfic_pkg::ADDR_CH_BASE) &&
                        (ch_off[7:2] < 6'(NC)) && (ch_off[1:0] == 2'b00);
  wire [3:0]  ch_idx  = ch_hit ? ch_off[5:2] : 4'h0;
  wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  wire [31:0] rd_ctrl   = 32'(ctrl);
  wire [31:0] rd_timing = {17'h00000, pulse_width, 1'b0, filt_time};
  wire [31:0] rd_state  = 32'({logic_cond_o, warn_stat, fault_o});
  wire [31:0] rd_cfg    = 32'(cfg[ch_idx]);
  wire [31:0] rd_word =
    (avs_address_i == sfic_pkg::ADDR_CTRL)     ? rd_ctrl :
    (avs_address_i == sfic_pkg::ADDR_TIMING)   ? rd_timing :
    (avs_address_i == sfic_pkg::ADDR_STATE)    ? rd_state :
    (avs_address_i == sfic_pkg::ADDR_IRQ_STAT) ? 32'(irq_stat) :
    (avs_address_i == sfic_pkg::ADDR_IRQ_MASK) ? 32'(irq_mask) :
    ch_hit                                     ? rd_cfg : 32'h00000000;

  // Byte-lane merge of the addressed word
  wire [31:0] wr_word = (rd_word & ~be_mask) | (avs_writedata_i & be_mask);
  wire        wr_ctrl = wr_en && avs_address_i == sfic_pkg::ADDR_CTRL;
  wire        wr_tim  = wr_en && avs_address_i == sfic_pkg::ADDR_TIMING;
  wire        wr_stat = wr_en && avs_address_i == sfic_pkg::ADDR_IRQ_STAT;
  wire        wr_mask = wr_en && avs_address_i == sfic_pkg::ADDR_IRQ_MASK;
  wire        wr_cfg  = wr_en && ch_hit;
  wire [sfic_pkg::EV_W-1:0] w1c =
    wr_stat ? wr_word[sfic_pkg::EV_W-1:0] : '0;
  wire sfic_pkg::sfic_chan_cfg_t cfg_wdat =
    sfic_pkg::sfic_chan_cfg_t'(wr_word[sfic_pkg::CFG_W-1:0]);
  wire [6:0] wr_filt  = wr_word[sfic_pkg::TIM_FILT_LSB +: 7];
  wire [6:0] wr_pulse = wr_word[sfic_pkg::TIM_PULSE_LSB +: 7];
  // New events win over a clear in the same cycle
  wire [sfic_pkg::EV_W-1:0] next_irq_stat = (irq_stat & ~w1c) | events;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else if (bus_req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= rd_word;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl        <= '0;
      filt_time   <= '0;
      pulse_width <= '0;
      irq_mask    <= '0;
      irq_stat    <= '0;
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_ctrl) ctrl <= wr_word[sfic_pkg::CTRL_W-1:0];
      if (wr_mask) irq_mask <= wr_word[sfic_pkg::EV_W-1:0];
      if (wr_tim) begin
        filt_time   <= sfic_pkg::clamp_us(wr_filt);
        pulse_width <= sfic_pkg::clamp_us(wr_pulse);
      end
    end
  end

  // Range is forced into the set the channel type allows
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < NC; i++) begin
      if (!rst_n_i) begin
        cfg[i]     <= sfic_pkg::CFG_RST;
        cfg[i].rng <= sfic_pkg::legal_range(4'(i), sfic_pkg::RG_LOW);
      end else if (wr_cfg && ch_idx == 4'(i)) begin
        cfg[i]     <= cfg_wdat;
        cfg[i].rng <= sfic_pkg::legal_range(4'(i), cfg_wdat.rng);
      end
    end
  end

  // Registered outputs toward the analog side and sequencing engine
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      afe_ctrl_o    <= '0;
      pulldown_en_o <= '0;
      fault_o       <= '0;
      warn_stat     <= '0;
      warn_o        <= 1'b0;
      logic_cond_o  <= '0;
      irq_o         <= 1'b0;
    end else begin
      afe_ctrl_o    <= next_afe;
      pulldown_en_o <= pd_sel & logic_mode;
      fault_o       <= next_fault;
      warn_stat     <= next_warn;
      warn_o        <= |next_warn;
      logic_cond_o  <= next_logic;
      irq_o         <= |(next_irq_stat & irq_mask);
    end
  end

  // Checks
  sequence s_req_wait;
    bus_req && avs_waitrequest_o;
  endsequence

  sequence s_done;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  chk_bus_answer: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_req_wait |=> s_done)
    else $error("bus request not answered after one wait cycle");

  chk_dual_exclusive: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) (fault_o[NC-1:ND] & warn_stat) == '0)
    else $error("dual channel reports fault and warning together");

  chk_range_legal: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    cfg[0].rng inside {sfic_pkg::RG_POS, sfic_pkg::RG_HIGH} &&
    cfg[1].rng != sfic_pkg::RG_HIGH && cfg[5].rng == sfic_pkg::RG_LOW)
    else $error("range outside the set allowed for the channel");

  chk_partner_range: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) $past(logic_mode[4]) |->
    afe_ctrl_o[9].rng == $past(cfg[0].rng) && afe_ctrl_o[9].partner_sel)
    else $error("secondary detector range differs from partner");

  chk_warn_or: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) warn_o == (|warn_stat))
    else $error("warning output is not the OR of warnings");

  chk_uv_hyst: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    $past(uv_sync[2]) && $past(cfg[2].uv_thr) < 8'he0 |->
    afe_ctrl_o[2].uv_code ==
      $past(cfg[2].uv_thr) + 8'($past(cfg[2].hyst_code)))
    else $error("undervoltage trip code lacks hysteresis");

  chk_filter_hold: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) $rose(flt[2]) && filt_time >= 7'h02 |->
    $past(sync_b[2], 1) && $past(sync_b[2], US_DIV + 1))
    else $error("filter passed a pulse shorter than the timeout");

  chk_level_follow: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) logic_mode[0] && !edge_mode[0] |=>
    logic_cond_o[0] == $past(lg_flt[0]))
    else $error("level-mode logic output does not follow input");

  chk_edge_pulse: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    logic_mode[0] && edge_mode[0] && lg_flt[0] != lg_prev[0] |=>
    ##1 logic_cond_o[0])
    else $error("edge did not produce an output pulse");

  chk_irq_level: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) irq_o == $past(|(next_irq_stat & irq_mask)))
    else $error("interrupt output disagrees with masked status");

endmodule

// ===== tb/sfic_rail_model.sv
// Far side of the block: rail comparators and the dual-function pins.
// Rails are given as codes on the threshold scale of each channel.
module sfic_rail_model (
  input  wire logic                                        clk_sys_i,
  input  wire sfic_pkg::sfic_afe_ctrl_t [sfic_pkg::NUM_CH-1:0] afe_i,
  input  wire logic [sfic_pkg::NUM_CH-1:0][7:0]            rail_i,
  input  wire logic [4:0]                                  pin_val_i,
  input  wire logic [4:0]                                  pin_drv_i,
  input  wire logic [4:0]                                  pulldown_en_i,
  output logic      [sfic_pkg::NUM_CH-1:0]                 uv_cmp_o,
  output logic      [sfic_pkg::NUM_CH-1:0]                 ov_cmp_o,
  output logic      [4:0]                                  pin_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [4:0] last_val;

  // Secondary detectors look at the rail of their fixed partner
  always_comb begin
    for (int c = 0; c < sfic_pkg::NUM_CH; c++) begin
      int src;
      src = (c >= 5 && afe_i[c].partner_sel) ? ((c == 9) ? 0 : c - 4) : c;
      uv_cmp_o[c] = rail_i[src] < afe_i[c].uv_code;
      ov_cmp_o[c] = rail_i[src] > afe_i[c].ov_code;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    for (int k = 0; k < 5; k++) begin
      if (pin_drv_i[k]) last_val[k] <= pin_val_i[k];
    end
  end

  // A floating pin without pull-down is not trusted to hold its level
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      if (pin_drv_i[k]) pin_o[k] = pin_val_i[k];
      else if (pulldown_en_i[k]) pin_o[k] = 1'b0;
      else pin_o[k] = ~last_val[k];
    end
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench of the supply fault input block.
// Drives the register bus and the rail model; judges outputs per scenario.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys_i;
  logic        rst_n_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [9:0]  uv_cmp;
  logic [9:0]  ov_cmp;
  logic [4:0]  pin;
  logic [4:0]  pin_val;
  logic [4:0]  pin_drv;
  logic [9:0][7:0] rail;
  sfic_pkg::sfic_afe_ctrl_t [9:0] afe_ctrl_o;
  logic [4:0]  pulldown_en_o;
  logic [9:0]  fault_o;
  logic        warn_o;
  logic [4:0]  logic_cond_o;
  logic        irq_o;
  int          mismatches;
  int          num_checks;
  logic [31:0] rd;
  int          n;

  sfic_top u_sfic_top (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .uv_cmp_i(uv_cmp),
    .ov_cmp_i(ov_cmp), .dual_function_input_i(pin),
    .afe_ctrl_o(afe_ctrl_o), .pulldown_en_o(pulldown_en_o),
    .fault_o(fault_o), .warn_o(warn_o), .logic_cond_o(logic_cond_o),
    .irq_o(irq_o));

  sfic_rail_model u_sfic_rail_model (
    .clk_sys_i(clk_sys_i), .afe_i(afe_ctrl_o), .rail_i(rail),
    .pin_val_i(pin_val), .pin_drv_i(pin_drv),
    .pulldown_en_i(pulldown_en_o), .uv_cmp_o(uv_cmp), .ov_cmp_o(ov_cmp),
    .pin_o(pin));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int guard;
    guard = 0;
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    do begin
      @(posedge clk_sys_i);
      guard++;
    end while (avs_waitrequest_o !== 1'b0 && guard < 100);
    if (guard >= 100) chk(32'h1, 32'h0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  function automatic logic [31:0] cfg(input int r, t, h, ov, uv);
    return {7'h0, 2'(r), 2'(t), 5'(h), 8'(ov), 8'(uv)};
  endfunction

  function automatic logic cur(input int s);
    if (s < 10) return fault_o[s];
    if (s == 10) return warn_o;
    if (s < 16) return logic_cond_o[s-11];
    return irq_o;
  endfunction

  // Counts edges until the selected output shows val
  task automatic wait_for(input int s, input logic val, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys_i);
      cnt++;
    end while (cur(s) !== val && cnt < 3000);
  endtask

  task automatic t_reset_and_ranges();
    bus(0, 8'h40, 0, rd);
    chk(rd, cfg(2, 0, 0, 8'hff, 8'h00));
    bus(0, 8'h00, 0, rd);
    chk(rd, 32'h0);
    bus(0, 8'h3c, 0, rd);
    chk(rd, 32'h0);
    bus(1, 8'h40, cfg(0, 0, 0, 8'hff, 0), rd);
    bus(0, 8'h40, 0, rd);
    chk(rd[24:23], 2'd2);
    bus(1, 8'h44, cfg(3, 0, 0, 8'hff, 0), rd);
    bus(0, 8'h44, 0, rd);
    chk(rd[24:23], 2'd2);
    bus(1, 8'h54, cfg(2, 0, 0, 8'hff, 0), rd);
    bus(0, 8'h54, 0, rd);
    chk(rd[24:23], 2'd0);
    // Only the lowest lane lands; the rest of the word is kept
    avs_byteenable_i <= 4'h1;
    bus(1, 8'h48, 32'h0180_c055, rd);
    avs_byteenable_i <= 4'hf;
    bus(0, 8'h48, 0, rd);
    chk(rd, cfg(0, 0, 0, 8'hff, 8'h55));
  endtask

  task automatic t_fault_types();
    for (int t = 0; t < 4; t++) begin
      bus(1, 8'h48, cfg(0, t, 0, 8'hc0, 8'h40), rd);
      rail[2] <= 8'h20;
      repeat (10) @(posedge clk_sys_i);
      chk(fault_o[2], t != 1);
      chk(afe_ctrl_o[2].uv_code, 8'h40);
      rail[2] <= 8'he0;
      repeat (10) @(posedge clk_sys_i);
      chk(fault_o[2], t != 0);
      rail[2] <= 8'h80;
      repeat (10) @(posedge clk_sys_i);
    end
  endtask

  task automatic t_hysteresis();
    bus(1, 8'h48, cfg(0, 0, 31, 8'hc0, 8'h80), rd);
    rail[2] <= 8'h7f;
    repeat (10) @(posedge clk_sys_i);
    chk(afe_ctrl_o[2].uv_code, 8'h9f);
    rail[2] <= 8'h90;
    repeat (10) @(posedge clk_sys_i);
    chk(fault_o[2], 1'b1);
    rail[2] <= 8'ha0;
    repeat (10) @(posedge clk_sys_i);
    chk(fault_o[2], 1'b0);
    chk(afe_ctrl_o[2].uv_code, 8'h80);
    rail[2] <= 8'hd0;
    repeat (10) @(posedge clk_sys_i);
    chk(afe_ctrl_o[2].ov_code, 8'ha1);
    rail[2] <= 8'hb0;
    repeat (10) @(posedge clk_sys_i);
    chk(afe_ctrl_o[2].ov_code, 8'ha1);
    rail[2] <= 8'h90;
    repeat (10) @(posedge clk_sys_i);
    chk(afe_ctrl_o[2].ov_code, 8'hc0);
  endtask

  task automatic t_glitch();
    bus(1, 8'h04, 32'h0000_0002, rd);
    rail[2] <= 8'h10;
    repeat (8) @(posedge clk_sys_i);
    rail[2] <= 8'hc0;
    repeat (40) @(posedge clk_sys_i);
    chk(fault_o[2], 1'b0);
    rail[2] <= 8'h10;
    wait_for(2, 1'b1, n);
    chk(n >= 11 && n <= 30, 1'b1);
    rail[2] <= 8'hc0;
    wait_for(2, 1'b0, n);
    chk(n >= 11 && n <= 30, 1'b1);
  endtask

  task automatic t_logic_inputs();
    bus(1, 8'h00, 32'h0000_0401, rd);
    pin_drv[0] <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
    chk(pulldown_en_o, 5'h01);
    chk(logic_cond_o[0], 1'b0);
    chk(fault_o[5], 1'b0);
    pin_drv[0] <= 1'b1;
    pin_val[0] <= 1'b1;
    wait_for(11, 1'b1, n);
    chk(n >= 11 && n <= 30, 1'b1);
    bus(1, 8'h04, 32'h0000_0300, rd);
    bus(1, 8'h00, 32'h0000_0021, rd);
    repeat (10) @(posedge clk_sys_i);
    pin_val[0] <= 1'b0;
    wait_for(11, 1'b1, n);
    wait_for(11, 1'b0, n);
    chk(n >= 29 && n <= 33, 1'b1);
  endtask

  task automatic t_warning_irq();
    bus(1, 8'h00, 32'h0000_0010, rd);
    bus(1, 8'h64, cfg(0, 0, 0, 8'hff, 8'h80), rd);
    chk(afe_ctrl_o[9].partner_sel, 1'b1);
    chk(afe_ctrl_o[9].rng, sfic_pkg::RG_POS);
    rail[0] <= 8'h10;
    wait_for(10, 1'b1, n);
    chk(n < 3000, 1'b1);
    chk(fault_o[9], 1'b0);
    bus(0, 8'h08, 0, rd);
    chk(rd[14], 1'b1);
    chk(irq_o, 1'b0);
    bus(1, 8'h10, 32'h0000_4000, rd);
    wait_for(16, 1'b1, n);
    chk(n < 5, 1'b1);
    bus(1, 8'h0c, 32'h0000_4000, rd);
    wait_for(16, 1'b0, n);
    chk(n < 5, 1'b1);
  endtask

  initial begin
    #(60000 * 100);
    mismatches++;
    summarize();
  end

  initial begin
    mismatches = 0;
    num_checks = 0;
    rst_n_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    pin_val = 5'h00;
    pin_drv = 5'h1f;
    for (int c = 0; c < 10; c++) rail[c] = 8'h80;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset_and_ranges();
    t_fault_types();
    t_hysteresis();
    t_glitch();
    t_logic_inputs();
    t_warning_irq();
    summarize();
  end
endmodule
